// File: verilog/adsc_top.sv
`timescale 1ns/1ps
`include "adsc_cfg.svh"
module adsc_top (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // System events
  input  wire logic              soft_reset,
  input  wire logic              sleep_req,
  // Analog front end
  input  wire logic              cmp_in,
  output adsc_pkg::adsc_afe_s    afe,
  // Pin control and interrupt request
  output logic [3:0]             analog_pins,
  output logic [3:0]             digital_path_en,
  output logic                   irq
);
  import adsc_pkg::*;

  adsc_top_s r_reg;
  adsc_top_s r_next;
  logic      cmp_s;
  logic      tad_stb;
  logic      tad_restart;

  // ==========================================================================
  // Helpers

  // Only aligned word accesses select a register.
  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    return (a[11:2] == idx) && (a[1:0] == 2'b00);
  endfunction : hit

  function automatic logic mapped(input logic [11:0] a);
    return hit(a, `ADSC_IDX_CTRL) || hit(a, `ADSC_IDX_PINSEL) ||
           hit(a, `ADSC_IDX_RESULT_HIGH) || hit(a, `ADSC_IDX_RESULT_LOW) ||
           hit(a, `ADSC_IDX_FLAG) || hit(a, `ADSC_IDX_IRQ_ENABLE);
  endfunction : mapped

  // One successive-approximation decision: keep the trial bit when the
  // comparator says the input is at or above the trial level.
  function automatic logic [9:0] sar_step(input logic [9:0] s, input logic [3:0] k,
                                          input logic cmp);
    logic [9:0] v;
    logic [3:0] b;
    v = s;
    b = 4'd10 - k;
    if (!cmp) begin
      v[b] = 1'b0;
    end
    if (b != 4'd0) begin
      v[b - 4'd1] = 1'b1;
    end
    return v;
  endfunction : sar_step

  // High byte in [15:8], low byte in [7:0].
  function automatic logic [15:0] fmt(input logic [9:0] res, input logic right);
    logic [15:0] v;
    if (right) begin
      v = {6'b00_0000, res};
    end else begin
      v = {res, 6'b00_0000};
    end
    return v;
  endfunction : fmt

  // Register contents as software reads them; unimplemented bits stay zero.
  function automatic logic [7:0] read_byte(input adsc_top_s s, input logic [11:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (hit(a, `ADSC_IDX_CTRL)) begin
      v = {s.justify, s.ref_sel, 2'b00, s.channel, s.go, s.on};
    end
    if (hit(a, `ADSC_IDX_PINSEL)) begin
      v = {1'b0, s.clk_sel, s.analog};
    end
    if (hit(a, `ADSC_IDX_RESULT_HIGH)) begin
      v = s.res_high;
    end
    if (hit(a, `ADSC_IDX_RESULT_LOW)) begin
      v = s.res_low;
    end
    if (hit(a, `ADSC_IDX_FLAG)) begin
      v[`ADSC_FLAG_DONE] = s.flag;
    end
    if (hit(a, `ADSC_IDX_IRQ_ENABLE)) begin
      v[`ADSC_FLAG_DONE] = s.irq_en;
    end
    return v;
  endfunction : read_byte

  // ==========================================================================
  // Sub-blocks

  adsc_sync u_cmp_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (cmp_in),
    .sync_out (cmp_s)
  );

  adsc_tad_gen u_tad (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (tad_restart),
    .clk_sel (r_reg.clk_sel),
    .tad_stb (tad_stb)
  );

  // ==========================================================================
  // Next state

  always_comb begin
    logic        wr;
    logic        rd_setup;
    logic        done_evt;
    logic        rc_clk;
    logic [9:0]  sar_new;
    logic [15:0] res_f;
    logic        ctrl_wr;
    logic        pin_wr;
    logic        flag_wr;
    logic        ien_wr;
    wr          = psel && penable && pwrite;
    rd_setup    = psel && !penable && !pwrite;
    done_evt    = 1'b0;
    rc_clk      = (r_reg.clk_sel[1:0] == 2'b11);
    sar_new     = r_reg.sar;
    res_f       = 16'h0000;
    tad_restart = 1'b0;
    r_next      = r_reg;
    ctrl_wr     = wr && hit(paddr, `ADSC_IDX_CTRL);
    pin_wr      = wr && hit(paddr, `ADSC_IDX_PINSEL);
    flag_wr     = wr && hit(paddr, `ADSC_IDX_FLAG);
    ien_wr      = wr && hit(paddr, `ADSC_IDX_IRQ_ENABLE);

    // Conversion sequencing, one step per conversion clock strobe.
    // The first strobe only opens the trial; ten more decide bits 9 down to 0.
    case (r_reg.state)
      ADSC_IDLE: begin
        r_next.tad_cnt = 4'h0;
      end
      ADSC_CONV: begin
        if (tad_stb) begin
          if (r_reg.tad_cnt == 4'h0) begin
            r_next.sar     = `ADSC_SAR_FIRST;
            r_next.tad_cnt = 4'h1;
          end else begin
            sar_new    = sar_step(r_reg.sar, r_reg.tad_cnt, cmp_s);
            r_next.sar = sar_new;
            if (r_reg.tad_cnt == 4'(`ADSC_CONV_TADS - 1)) begin
              res_f           = fmt(sar_new, r_reg.justify);
              r_next.res_high = res_f[15:8];
              r_next.res_low  = res_f[7:0];
              r_next.go       = 1'b0;
              r_next.state    = ADSC_IDLE;
              done_evt        = 1'b1;
            end else begin
              r_next.tad_cnt = r_reg.tad_cnt + 4'h1;
            end
          end
        end
      end
      ADSC_ABORT: begin
        if (tad_stb) begin
          if (r_reg.tad_cnt == 4'(`ADSC_ABORT_TADS - 1)) begin
            r_next.state = ADSC_IDLE;
          end else begin
            r_next.tad_cnt = r_reg.tad_cnt + 4'h1;
          end
        end
      end
      default: begin
        r_next.state = ADSC_IDLE;
      end
    endcase

    // Register writes take effect at the access edge.
    if (ctrl_wr) begin
      r_next.justify = pwdata[`ADSC_CTRL_JUSTIFY];
      r_next.ref_sel = pwdata[`ADSC_CTRL_REF];
      r_next.channel = pwdata[`ADSC_CTRL_CHAN_HI:`ADSC_CTRL_CHAN_LO];
      r_next.on      = pwdata[`ADSC_CTRL_ON];
      // A start is taken only when the module was already on.
      if (pwdata[`ADSC_CTRL_GO] && r_reg.on && pwdata[`ADSC_CTRL_ON] &&
          r_reg.state == ADSC_IDLE && !r_reg.sleep_off) begin
        r_next.go      = 1'b1;
        r_next.state   = ADSC_CONV;
        r_next.tad_cnt = 4'h0;
        tad_restart    = 1'b1;
      end else if (!pwdata[`ADSC_CTRL_GO] && r_next.state == ADSC_CONV) begin
        // The prescaler restarts so that the wait is two whole periods.
        r_next.go      = 1'b0;
        r_next.sar     = r_reg.sar;
        r_next.state   = ADSC_ABORT;
        r_next.tad_cnt = 4'h0;
        tad_restart    = 1'b1;
      end
    end
    if (pin_wr) begin
      r_next.clk_sel = pwdata[`ADSC_PINSEL_CLK_HI:`ADSC_PINSEL_CLK_LO];
      r_next.analog  = pwdata[3:0];
    end
    if (flag_wr) begin
      r_next.flag = pwdata[`ADSC_FLAG_DONE];
    end
    if (ien_wr) begin
      r_next.irq_en = pwdata[`ADSC_FLAG_DONE];
    end

    // Sleep: a non-RC clock stops with the core, so the run is dropped.
    if (sleep_req && !rc_clk && r_reg.on) begin
      r_next.sleep_off = 1'b1;
    end
    // With the RC clock the run goes on through sleep; with no enabled
    // interrupt to wake the core the converter then powers down.
    if (sleep_req && rc_clk && done_evt && !r_reg.irq_en) begin
      r_next.sleep_off = 1'b1;
    end
    if (!sleep_req) begin
      r_next.sleep_off = 1'b0;
    end

    // Switching off, non-RC sleep or a device reset ends any run at once.
    if (!r_next.on || r_next.sleep_off || soft_reset) begin
      if (r_next.state != ADSC_IDLE) begin
        r_next.state = ADSC_IDLE;
        r_next.go    = 1'b0;
        r_next.sar   = r_reg.sar;
      end
    end
    if (soft_reset) begin
      {r_next.justify, r_next.ref_sel, r_next.channel,
       r_next.go, r_next.on} = 6'(`ADSC_CTRL_RESET);
      r_next.clk_sel   = `ADSC_CLKSEL_RESET;
      r_next.analog    = `ADSC_ANALOG_RESET;
      r_next.flag      = 1'b0;
      r_next.irq_en    = 1'b0;
      r_next.sleep_off = 1'b0;
    end

    // A completion in the same cycle as a software clear still sets the flag.
    if (done_evt && !soft_reset) begin
      r_next.flag = 1'b1;
    end

    // Read data and error are captured in the setup cycle.
    if (psel && !penable) begin
      r_next.prdata  = 32'h0000_0000;
      r_next.pslverr = !mapped(paddr);
      if (rd_setup) begin
        r_next.prdata[7:0] = read_byte(r_reg, paddr);
      end
    end
  end

  // ==========================================================================
  // State register
  // Results are cleared only by power-on; the device reset keeps them.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg         <= '0;
      r_reg.analog  <= `ADSC_ANALOG_RESET;
      r_reg.clk_sel <= `ADSC_CLKSEL_RESET;
      r_reg.state   <= ADSC_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Outputs

  // Every register answers in its access cycle, so no wait state is inserted.
  assign pready  = 1'b1;
  assign prdata  = r_reg.prdata;
  assign pslverr = r_reg.pslverr && psel && penable;

  // The comparator reaches the sequencer through four flip-flops, so a trial
  // needs five clocks to settle; the two fastest clock settings are too quick.
  always_comb begin
    afe.analog_on = r_reg.on && !r_reg.sleep_off;
    afe.ref_sel   = r_reg.ref_sel;
    afe.channel   = r_reg.channel;
    afe.sample    = afe.analog_on && (r_reg.state == ADSC_IDLE);
    afe.dac_code  = r_reg.sar;
  end

  // Analog pins lose input buffer, pull-up and change detection together.
  assign analog_pins     = r_reg.analog;
  assign digital_path_en = ~r_reg.analog;
  assign irq             = r_reg.flag && r_reg.irq_en;
endmodule : adsc_top

// File: verilog/adsc_cfg.svh
`ifndef ADSC_CFG_SVH
`define ADSC_CFG_SVH

// ==========================================================================
// Register indices; the byte address is four times the index.
`define ADSC_IDX_FLAG        10'h00C
`define ADSC_IDX_RESULT_HIGH 10'h01E
`define ADSC_IDX_CTRL        10'h01F
`define ADSC_IDX_IRQ_ENABLE  10'h08C
`define ADSC_IDX_RESULT_LOW  10'h09E
`define ADSC_IDX_PINSEL      10'h09F

// ==========================================================================
// Field positions.
`define ADSC_CTRL_JUSTIFY    7
`define ADSC_CTRL_REF        6
`define ADSC_CTRL_CHAN_HI    3
`define ADSC_CTRL_CHAN_LO    2
`define ADSC_CTRL_GO         1
`define ADSC_CTRL_ON         0
`define ADSC_PINSEL_CLK_HI   6
`define ADSC_PINSEL_CLK_LO   4
`define ADSC_FLAG_DONE       6

// ==========================================================================
// Reset values.
`define ADSC_CTRL_RESET      8'h00
`define ADSC_CLKSEL_RESET    3'h0
`define ADSC_ANALOG_RESET    4'hF

// ==========================================================================
// Timing.
`define ADSC_PCLK_KHZ        125000
`define ADSC_RC_MAX_KHZ      500
`define ADSC_RC_DIV          ((`ADSC_PCLK_KHZ + `ADSC_RC_MAX_KHZ - 1) / `ADSC_RC_MAX_KHZ)
`define ADSC_CONV_TADS       11
`define ADSC_ABORT_TADS      2
`define ADSC_SAR_FIRST       10'h200

`endif

// File: verilog/adsc_pkg.sv
package adsc_pkg;
  `include "adsc_cfg.svh"

  typedef enum logic [1:0] {ADSC_IDLE, ADSC_CONV, ADSC_ABORT} adsc_state_e;

  // Lines to the analog sample-and-hold and converter array.
  typedef struct packed {
    logic       analog_on;
    logic       ref_sel;
    logic [1:0] channel;
    logic       sample;
    logic [9:0] dac_code;
  } adsc_afe_s;

  typedef struct packed {
    logic        justify;
    logic        ref_sel;
    logic [1:0]  channel;
    logic        go;
    logic        on;
    logic [2:0]  clk_sel;
    logic [3:0]  analog;
    logic        flag;
    logic        irq_en;
    logic [7:0]  res_high;
    logic [7:0]  res_low;
    logic [9:0]  sar;
    logic [3:0]  tad_cnt;
    adsc_state_e state;
    logic        sleep_off;
    logic [31:0] prdata;
    logic        pslverr;
  } adsc_top_s;

  typedef struct packed {
    logic [7:0] cnt;
  } adsc_tad_s;

  typedef struct packed {
    logic [2:0] ff;
    logic       value;
  } adsc_sync_s;
endpackage : adsc_pkg

// File: verilog/adsc_sync.sv
`timescale 1ns/1ps
module adsc_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Asynchronous level in, clean level out
  input  wire logic async_in,
  output logic      sync_out
);
  import adsc_pkg::*;

  adsc_sync_s r_reg;
  adsc_sync_s r_next;

  // The first stage feeds only the second; the accepted level changes once
  // the second and third stages agree.
  always_comb begin
    r_next    = r_reg;
    r_next.ff = {r_reg.ff[1:0], async_in};
    if (r_reg.ff[1] == r_reg.ff[2]) begin
      r_next.value = r_reg.ff[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sync_out = r_reg.value;
endmodule : adsc_sync

// File: verilog/adsc_tad_gen.sv
`timescale 1ns/1ps
module adsc_tad_gen (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       restart,
  input  wire logic [2:0] clk_sel,
  // One-cycle strobe at the end of each conversion clock period
  output logic            tad_stb
);
  import adsc_pkg::*;

  adsc_tad_s r_reg;
  adsc_tad_s r_next;

  function automatic logic [7:0] last_count(input logic [2:0] sel);
    logic [7:0] v;
    v = 8'h00;
    if (sel[1:0] == 2'b11) begin
      v = 8'(`ADSC_RC_DIV - 1);
    end else begin
      case (sel)
        3'b000:  v = 8'h01;
        3'b100:  v = 8'h03;
        3'b001:  v = 8'h07;
        3'b101:  v = 8'h0F;
        3'b010:  v = 8'h1F;
        3'b110:  v = 8'h3F;
        default: v = 8'h01;
      endcase
    end
    return v;
  endfunction : last_count

  assign tad_stb = !restart && (r_reg.cnt >= last_count(clk_sel));

  always_comb begin
    r_next = r_reg;
    if (restart || tad_stb) begin
      r_next.cnt = 8'h00;
    end else begin
      r_next.cnt = r_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule : adsc_tad_gen

// File: bench/adsc_top_sva.sv
`timescale 1ns/1ps
module adsc_top_sva (
  // Clock and reset
  input wire logic             pclk,
  input wire logic             presetn,
  // APB slave
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // System events
  input wire logic             soft_reset,
  input wire logic             sleep_req,
  // Analog front end
  input wire logic             cmp_in,
  input adsc_pkg::adsc_afe_s   afe,
  // Pins and interrupt
  input wire logic [3:0]       analog_pins,
  input wire logic [3:0]       digital_path_en,
  input wire logic             irq
);
  import adsc_pkg::*;
  wire wr_any = psel & penable & pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====================
  // Steps of a conversion and of a register write.
  sequence s_start;
    $fell(afe.sample) && afe.analog_on;
  endsequence
  sequence s_wr(logic [11:0] a);
    wr_any && paddr == a && !soft_reset;
  endsequence
  // ====================
  // An abort may bring tracking back early, so only the first cycles are held.
  a_conv_hold: assert property (s_start |=> !afe.sample [*5])
    else $error("tracking resumed too early");
  a_first_trial: assert property (s_start |-> ##[1:520]
    (afe.dac_code == 10'h200 || afe.sample || !afe.analog_on)) else $error("no first trial");
  a_slverr_gate: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access");
  a_unmapped_err: assert property (psel && penable && !(paddr inside {12'h030, 12'h078,
    12'h07C, 12'h230, 12'h278, 12'h27C}) |-> pslverr) else $error("unmapped not refused");
  a_pins_inverse: assert property (digital_path_en == ~analog_pins)
    else $error("digital path not inverse");
  a_pins_write: assert property (s_wr(12'h27C) |=> analog_pins == $past(pwdata[3:0]))
    else $error("analog pins not written");
  a_ref_follow: assert property (s_wr(12'h07C) |=> afe.ref_sel == $past(pwdata[6]))
    else $error("reference select wrong");
  a_chan_follow: assert property (s_wr(12'h07C) |=> afe.channel == $past(pwdata[3:2]))
    else $error("channel wrong");
  a_sample_on: assert property (afe.sample |-> afe.analog_on)
    else $error("sampling while off");
  a_irq_cause: assert property ($rose(irq) |-> afe.sample || $past(wr_any)
    || $past(wr_any, 2)) else $error("interrupt without cause");
endmodule : adsc_top_sva

// File: bench/adsc_sar_model.sv
`timescale 1ns/1ps
module adsc_sar_model (
  // Clock
  input wire logic            pclk,
  // Converter side
  input adsc_pkg::adsc_afe_s  afe,
  input wire logic [9:0]      vin,
  output logic                cmp_in
);
  import adsc_pkg::*;
  logic junk_reg = 1'b0;
  // Outside a conversion the comparator output means nothing, so it must not look stable.
  always_ff @(posedge pclk) begin
    junk_reg <= ~junk_reg;
  end
  // The pins are inputs on this side, so only the source sets their voltage.
  assign cmp_in = (afe.analog_on && !afe.sample) ? (vin >= afe.dac_code) : junk_reg;
endmodule : adsc_sar_model

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import adsc_pkg::*;
  localparam logic [11:0] A_FLAG = 12'h030;
  localparam logic [11:0] A_RH   = 12'h078;
  localparam logic [11:0] A_CTRL = 12'h07C;
  localparam logic [11:0] A_IEN  = 12'h230;
  localparam logic [11:0] A_RL   = 12'h278;
  localparam logic [11:0] A_PSEL = 12'h27C;
  localparam int          TN [8] = '{2, 4, 8, 16, 32, 64, 250, 250};
  localparam int          SL [8] = '{0, 4, 1, 5, 2, 6, 3, 7};
  logic        pclk, presetn, psel, penable, pwrite, soft_reset, sleep_req, cmp_in;
  logic        pready, pslverr, irq, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  analog_pins, digital_path_en;
  logic [9:0]  vin;
  logic [7:0]  eh, el, c;
  adsc_afe_s   afe;
  int          err_total, n_checks, cnt;

  adsc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .soft_reset(soft_reset), .sleep_req(sleep_req), .cmp_in(cmp_in),
    .afe(afe), .analog_pins(analog_pins), .digital_path_en(digital_path_en), .irq(irq));
  adsc_sar_model sar (.pclk(pclk), .afe(afe), .vin(vin), .cmp_in(cmp_in));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ====================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  // Entered just after an edge; returns one edge after the access edge so calls never collide.
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rdat = prdata;
    serr = pslverr;
    if (k >= 16) begin
      err_total++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : acc

  // Counts edges from the write edge until tracking resumes.
  task automatic wait_sample;
    cnt = 1;
    #1;
    while (afe.sample !== 1'b1 && cnt < 3000) begin
      @(posedge pclk);
      #1;
      cnt++;
    end
    if (cnt >= 3000) begin
      err_total++;
      close_out();
    end
    @(posedge pclk);
  endtask : wait_sample

  // ====================
  initial begin
    {presetn, psel, penable, pwrite, soft_reset, sleep_req} = '0;
    paddr = '0;
    pwdata = '0;
    vin = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    acc(0, A_CTRL, 8'h00);
    chk(rdat, 32'h0000_0000);
    acc(0, A_PSEL, 8'h00);
    chk(rdat, 32'h0000_000F);
    acc(1, A_PSEL, 8'hFF);
    acc(0, A_PSEL, 8'h00);
    chk(rdat, 32'h0000_007F);
    acc(1, A_PSEL, 8'h70);
    chk(digital_path_en, 32'h0000_000F);
    chk(analog_pins, 32'h0000_0000);
    acc(1, A_CTRL, 8'hFF);
    acc(0, A_CTRL, 8'h00);
    chk(rdat, 32'h0000_00CD);
    chk({afe.ref_sel, afe.channel}, 32'h0000_0007);
    acc(1, A_IEN, 8'h40);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      vin <= 10'h13B + 10'(i * 97);
      acc(1, A_FLAG, 8'h00);
      chk(irq, 32'h0000_0000);
      acc(1, A_PSEL, {1'b0, 3'(SL[i]), 4'hF});
      c = {i[0], 7'h4F};
      acc(1, A_CTRL, c);
      wait_sample();
      chk(cnt, 11 * TN[i]);
      acc(0, A_CTRL, 8'h00);
      chk(rdat, 32'(c & 8'hFD));
      acc(0, A_FLAG, 8'h00);
      chk(rdat, 32'h0000_0040);
      chk(irq, 32'h0000_0001);
      eh = i[0] ? {6'h00, vin[9:8]} : vin[9:2];
      el = i[0] ? vin[7:0] : {vin[1:0], 6'h00};
      // Short periods give the comparator too little settling time to judge the value.
      if (TN[i] >= 8) begin
        acc(0, A_RH, 8'h00);
        chk(rdat, 32'(eh));
        acc(0, A_RL, 8'h00);
        chk(rdat, 32'(el));
      end
    end
    $display("test conversions done");
    acc(1, A_PSEL, 8'h1F);
    acc(1, A_CTRL, 8'h4F);
    acc(0, A_FLAG, 8'h00);
    chk(rdat, 32'h0000_0040);
    repeat (10) @(posedge pclk);
    acc(1, A_CTRL, 8'h4D);
    wait_sample();
    chk(cnt, 16);
    acc(0, A_RH, 8'h00);
    chk(rdat, 32'(eh));
    $display("test abort done");
    acc(1, A_CTRL, 8'h4F);
    repeat (12) @(posedge pclk);
    sleep_req <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(afe.analog_on, 32'h0000_0000);
    acc(0, A_CTRL, 8'h00);
    chk(rdat, 32'h0000_004D);
    sleep_req <= 1'b0;
    acc(0, A_RL, 8'h00);
    chk(rdat, 32'(el));
    acc(1, A_FLAG, 8'h00);
    // Only the RC setting gives a period of 1.6 us or more at this clock.
    acc(1, A_PSEL, 8'h3F);
    acc(1, A_CTRL, 8'hCF);
    sleep_req <= 1'b1;
    wait_sample();
    chk(cnt, 11 * TN[7]);
    chk({irq, afe.analog_on}, 32'h0000_0003);
    sleep_req <= 1'b0;
    acc(0, A_RL, 8'h00);
    chk(rdat, 32'(el));
    $display("test sleep done");
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    acc(0, A_CTRL, 8'h00);
    chk(rdat, 32'h0000_0000);
    chk(afe.analog_on, 32'h0000_0000);
    acc(0, A_PSEL, 8'h00);
    chk(rdat, 32'h0000_000F);
    acc(0, A_RH, 8'h00);
    chk(rdat, 32'(eh));
    acc(0, 12'h004, 8'h00);
    chk(serr, 32'h0000_0001);
    chk(rdat, 32'h0000_0000);
    $display("test reset done");
    close_out();
  end
endmodule : tb_top

bind adsc_top adsc_top_sva sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .soft_reset(soft_reset), .sleep_req(sleep_req),
  .cmp_in(cmp_in), .afe(afe), .analog_pins(analog_pins),
  .digital_path_en(digital_path_en), .irq(irq));
